/* include/tpd_pkg.sv */
// tpd_pkg: timing constants, reset values and state encoding for the powerdown control
package tpd_pkg;

    // clock rate
    localparam longint unsigned TPD_CLK_HZ = 64'd250_000_000;
    localparam longint unsigned TPD_CLK_MHZ = 64'd250;

    // intervals as printed, in their own units
    localparam longint unsigned TPD_IDLE_TIME_S = 64'd30;
    localparam longint unsigned TPD_INVALID_TIME_US = 64'd30;
    localparam longint unsigned TPD_VALID_TIME_US = 64'd1;
    localparam longint unsigned TPD_WAKE_TIME_US = 64'd100;

    // intervals as clock cycles (all come out whole at this rate)
    localparam longint unsigned TPD_IDLE_CYC = TPD_IDLE_TIME_S * TPD_CLK_HZ;
    localparam longint unsigned TPD_INVALID_CYC = TPD_INVALID_TIME_US * TPD_CLK_MHZ;
    localparam longint unsigned TPD_VALID_CYC = TPD_VALID_TIME_US * TPD_CLK_MHZ;
    localparam longint unsigned TPD_WAKE_CYC = TPD_WAKE_TIME_US * TPD_CLK_MHZ;

    // default channel counts
    localparam int TPD_NUM_TX = 3;
    localparam int TPD_NUM_RX = 5;

    // power sequencing states, gray coded along off -> wake -> on
    typedef enum logic [1:0] {
        TPD_ST_OFF = 2'h0,
        TPD_ST_WAKE = 2'h1,
        TPD_ST_ON = 2'h3
    } tpd_state_e;

    // reset values
    localparam tpd_state_e TPD_RST_STATE = TPD_ST_OFF;
    localparam logic TPD_RST_EXPIRED = 1'h1;
    localparam logic TPD_RST_INVALID_N = 1'h0;
    localparam logic TPD_RST_MONITOR_EN = 1'h1;

endpackage : tpd_pkg

/* rtl/tpd_edge_det.sv */
// tpd_edge_det: one-cycle pulse when any bit of a vector changes
module tpd_edge_det #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] sig,
    output logic any_edge
);
    if (WIDTH < 1) begin : g_bad_width
        $error("tpd_edge_det: WIDTH must be at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] prev;
        logic armed;
        logic edge_seen;
    } tpd_edge_s;

    tpd_edge_s cur_ff;
    tpd_edge_s nxt_cur;

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.prev = sig;
        nxt_cur.armed = 1'h1;
        // no edge on the first sample after reset: prev holds no real history yet
        nxt_cur.edge_seen = cur_ff.armed & (|(sig ^ cur_ff.prev));
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign any_edge = cur_ff.edge_seen;

endmodule : tpd_edge_det

/* rtl/tpd_timer.sv */
// tpd_timer: saturating cycle counter that flags when its limit is reached
module tpd_timer #(
    parameter longint unsigned LIMIT = 64'd1
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic run,
    input wire logic clear,
    output logic done
);
    localparam int CW = $clog2(LIMIT + 64'd1);

    if (LIMIT < 64'd1) begin : g_bad_limit
        $error("tpd_timer: LIMIT must be at least 1");
    end

    typedef struct packed {
        logic [CW-1:0] count;
        logic done;
    } tpd_timer_s;

    tpd_timer_s cur_ff;
    tpd_timer_s nxt_cur;

    always_comb begin
        nxt_cur = cur_ff;
        if (clear) begin
            nxt_cur.count = '0;
        end else if (run && (cur_ff.count != CW'(LIMIT))) begin
            nxt_cur.count = cur_ff.count + CW'(1);
        end
        nxt_cur.done = (nxt_cur.count == CW'(LIMIT));
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign done = cur_ff.done;

endmodule : tpd_timer

/* rtl/tpd_powerdown_ctrl.sv */
// tpd_powerdown_ctrl: powerdown control of a multi-channel serial line transceiver
//
// How it works
// - entering powerdown turns the charge pump off and tristates every transmitter output
// - shutdown override low forces powerdown whatever the auto-disable input does
// - both control inputs high keeps the device active, inactivity powerdown off
// - monitor variant: inverting receiver outputs off in powerdown, monitor output stays on
// - leaving powerdown and resuming transmission takes at most the 100 us wake interval plus a few cycles
// - auto-disable low: wake only when both inputs high or on an input transition
// - falling auto-disable edge keeps the device up for a fresh 30 s
// - invalid flag goes low after invalid levels on all receivers beyond 30 us
// - invalid flag goes high 1 us after a valid level on any receiver
// - invalid detector runs in every mode and never alters power state itself
// - 30 s without transmitter or receiver transitions powers down pump and transmitters
// - after inactivity powerdown any input transition brings the device back up
// - inactivity powerdown acts only with auto-disable low and shutdown override high
// - in powerdown the idle timer stays expired until auto-disable rises or a transition
// - floating receivers read as invalid levels, so the flag goes low
// - flag on shutdown override: stay down until valid levels and a transition
// - recovery from automatic powerdown completes within about 100 us of the waking edge
// - ready low in powerdown, high in power-up once the pump rail is good or the wake interval runs out
module tpd_powerdown_ctrl
    import tpd_pkg::*;
#(
    parameter int NUM_TX = TPD_NUM_TX,
    parameter int NUM_RX = TPD_NUM_RX,
    parameter bit HAS_MONITOR = 1'b1,
    parameter longint unsigned IDLE_CYCLES = TPD_IDLE_CYC,
    parameter longint unsigned INVALID_CYCLES = TPD_INVALID_CYC,
    parameter longint unsigned VALID_CYCLES = TPD_VALID_CYC,
    parameter longint unsigned WAKE_CYCLES = TPD_WAKE_CYC
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic shutdown_override_input,
    input wire logic auto_disable_input,
    input wire logic [NUM_TX-1:0] tx_data_in,
    input wire logic [NUM_RX-1:0] rx_data_in,
    input wire logic [NUM_RX-1:0] rx_level_valid,
    input wire logic pump_rail_ok,
    output logic charge_pump_en,
    output logic tx_out_en,
    output logic rx_inv_out_en,
    output logic rx_monitor_out_en,
    output logic ready,
    output logic invalid_n,
    output logic powered_down,
    output logic idle_expired
);
    localparam int IW = $clog2(IDLE_CYCLES + 64'd1);

    if (NUM_TX < 1 || NUM_RX < 1) begin : g_bad_channels
        $error("tpd_powerdown_ctrl: need at least one transmitter and one receiver");
    end
    if (IDLE_CYCLES < 64'd2 || INVALID_CYCLES < 64'd1) begin : g_bad_idle
        $error("tpd_powerdown_ctrl: idle and invalid intervals too short");
    end
    if (VALID_CYCLES < 64'd1 || WAKE_CYCLES < 64'd1) begin : g_bad_wake
        $error("tpd_powerdown_ctrl: valid and wake intervals must be at least one cycle");
    end

    typedef struct packed {
        tpd_state_e st;
        logic [IW-1:0] idle_cnt;
        logic expired;
        logic invalid_n;
        logic charge_pump_en;
        logic tx_out_en;
        logic rx_inv_out_en;
        logic rx_monitor_out_en;
        logic ready;
        logic powered_down;
    } tpd_ctrl_s;

    localparam tpd_ctrl_s TPD_RST_CTRL = '{
        st: TPD_RST_STATE,
        idle_cnt: '0,
        expired: TPD_RST_EXPIRED,
        invalid_n: TPD_RST_INVALID_N,
        charge_pump_en: 1'h0,
        tx_out_en: 1'h0,
        rx_inv_out_en: 1'h0,
        rx_monitor_out_en: TPD_RST_MONITOR_EN,
        ready: 1'h0,
        powered_down: 1'h1
    };

    tpd_ctrl_s cur_ff;
    tpd_ctrl_s nxt_cur;

    logic any_transition;
    logic all_invalid;
    logic invalid_done;
    logic valid_done;
    logic wake_done;
    logic power_req;

    // transitions on every transmitter and receiver input
    tpd_edge_det #(
        .WIDTH(NUM_TX + NUM_RX)
    ) u_edges (
        .clock(clock),
        .resetn(resetn),
        .sig({tx_data_in, rx_data_in}),
        .any_edge(any_transition)
    );

    // floating inputs are pulled to ground outside and simply read as not valid
    assign all_invalid = ~|rx_level_valid;

    // invalid flag runs in every mode; "more than" needs one cycle past the interval
    tpd_timer #(
        .LIMIT(INVALID_CYCLES + 64'd1)
    ) u_invalid_tmr (
        .clock(clock),
        .resetn(resetn),
        .run(all_invalid),
        .clear(~all_invalid),
        .done(invalid_done)
    );

    tpd_timer #(
        .LIMIT(VALID_CYCLES)
    ) u_valid_tmr (
        .clock(clock),
        .resetn(resetn),
        .run(~all_invalid),
        .clear(all_invalid),
        .done(valid_done)
    );

    // bounds the wait for the pump rail so transmission always resumes in time
    tpd_timer #(
        .LIMIT(WAKE_CYCLES)
    ) u_wake_tmr (
        .clock(clock),
        .resetn(resetn),
        .run(cur_ff.st == TPD_ST_WAKE),
        .clear(cur_ff.st != TPD_ST_WAKE),
        .done(wake_done)
    );

    always_comb begin
        nxt_cur = cur_ff;
        power_req = 1'h0;

        // inactivity timer and its expired flag
        if (auto_disable_input) begin
            // forced on: timer held clear, so its fall starts a full interval
            nxt_cur.idle_cnt = '0;
            nxt_cur.expired = 1'h0;
        end else if (any_transition) begin
            // a transition restarts the idle interval and wakes the device
            nxt_cur.idle_cnt = '0;
            nxt_cur.expired = 1'h0;
        end else if (!shutdown_override_input || cur_ff.st == TPD_ST_OFF) begin
            // while down the timer stays expired; only a rise or transition clears it
            nxt_cur.idle_cnt = '0;
            nxt_cur.expired = 1'h1;
        end else if (!cur_ff.expired) begin
            // counting only with auto-disable low and override high
            if (cur_ff.idle_cnt == IW'(IDLE_CYCLES - 64'd1)) begin
                nxt_cur.expired = 1'h1;
            end else begin
                nxt_cur.idle_cnt = cur_ff.idle_cnt + IW'(1);
            end
        end

        // override dominates; forced on ignores the idle timer; flag has no say here
        power_req = shutdown_override_input
            & (auto_disable_input | ~nxt_cur.expired);

        // power sequencing
        case (cur_ff.st)
            TPD_ST_OFF: begin
                if (power_req) begin
                    nxt_cur.st = TPD_ST_WAKE;
                end
            end
            TPD_ST_WAKE: begin
                if (!power_req) begin
                    nxt_cur.st = TPD_ST_OFF;
                end else if (pump_rail_ok || wake_done) begin
                    nxt_cur.st = TPD_ST_ON;
                end
            end
            TPD_ST_ON: begin
                if (!power_req) begin
                    nxt_cur.st = TPD_ST_OFF;
                end
            end
            default: begin
                nxt_cur.st = TPD_ST_OFF;
            end
        endcase

        // invalid flag: low after sustained invalid levels, high shortly after a valid one
        if (invalid_done) begin
            nxt_cur.invalid_n = 1'h0;
        end else if (valid_done) begin
            nxt_cur.invalid_n = 1'h1;
        end

        // outputs follow the next state so each comes straight from a flip-flop
        nxt_cur.powered_down = (nxt_cur.st == TPD_ST_OFF);
        nxt_cur.charge_pump_en = (nxt_cur.st != TPD_ST_OFF);
        // transmitters stay tristated until the rail is up or the wake interval runs out, avoiding output glitches
        nxt_cur.tx_out_en = (nxt_cur.st == TPD_ST_ON);
        nxt_cur.ready = (nxt_cur.st == TPD_ST_ON);
        if (HAS_MONITOR) begin
            nxt_cur.rx_inv_out_en = (nxt_cur.st != TPD_ST_OFF);
        end else begin
            nxt_cur.rx_inv_out_en = 1'h1;
        end
        nxt_cur.rx_monitor_out_en = 1'h1;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cur_ff <= TPD_RST_CTRL;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign charge_pump_en = cur_ff.charge_pump_en;
    assign tx_out_en = cur_ff.tx_out_en;
    assign rx_inv_out_en = cur_ff.rx_inv_out_en;
    assign rx_monitor_out_en = cur_ff.rx_monitor_out_en;
    assign ready = cur_ff.ready;
    assign invalid_n = cur_ff.invalid_n;
    assign powered_down = cur_ff.powered_down;
    assign idle_expired = cur_ff.expired;

endmodule : tpd_powerdown_ctrl

/* verif/tpd_host_model.sv */
// tpd_host_model: host power management driving the control inputs and the pump rail
module tpd_host_model (
    input wire logic clock,
    input wire logic [1:0] mode,
    input wire logic [1:0] man_ctl,
    input wire logic rail_slow,
    input wire logic charge_pump_en,
    input wire logic invalid_n,
    output logic shutdown_override_input,
    output logic auto_disable_input,
    output logic pump_rail_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] rail_cnt;
    // mode 1: flag on both inputs; mode 3: flag on override, auto-disable held low
    assign shutdown_override_input = mode[0] ? invalid_n : man_ctl[1];
    assign auto_disable_input = mode[0] ? invalid_n & ~mode[1] : man_ctl[0];
    // rail settles three cycles after the pump starts; a slow rail never settles
    always @(posedge clock) begin
        if (!charge_pump_en) rail_cnt <= 2'h0;
        else if (rail_cnt != 2'h3) rail_cnt <= rail_cnt + 2'h1;
    end
    assign pump_rail_ok = !rail_slow && rail_cnt == 2'h3;
endmodule : tpd_host_model

/* verif/tpd_checker_properties.sv */
// tpd_checker: port-level properties of the powerdown control
module tpd_checker #(
    parameter int NUM_TX = 3,
    parameter int NUM_RX = 5,
    parameter longint unsigned INVALID_CYCLES = 64'h1E
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic shutdown_override_input,
    input wire logic auto_disable_input,
    input wire logic [NUM_TX-1:0] tx_data_in,
    input wire logic [NUM_RX-1:0] rx_data_in,
    input wire logic [NUM_RX-1:0] rx_level_valid,
    input wire logic charge_pump_en,
    input wire logic tx_out_en,
    input wire logic rx_inv_out_en,
    input wire logic rx_monitor_out_en,
    input wire logic ready,
    input wire logic invalid_n,
    input wire logic powered_down,
    input wire logic idle_expired
);
    timeunit 1ns;
    timeprecision 1ps;
    // sized for the shortened wake count of the bench
    localparam int WAKE_MAX = 53;
    logic [7:0] inv_cnt_ff;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    // saturating so a long invalid run never wraps back to zero
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) inv_cnt_ff <= 8'h00;
        else if (|rx_level_valid) inv_cnt_ff <= 8'h00;
        else if (inv_cnt_ff != 8'hFF) inv_cnt_ff <= inv_cnt_ff + 8'h01;
    end
    a_off_pump_tx: assert property (powered_down |-> !charge_pump_en && !tx_out_en)
        else $error("pump or transmitters on in powerdown");
    a_override_off: assert property (!shutdown_override_input |=> powered_down)
        else $error("override low left device up");
    a_both_high_on: assert property (
        shutdown_override_input && auto_disable_input |=> !powered_down)
        else $error("forced on but powered down");
    a_rx_outputs: assert property (rx_monitor_out_en && rx_inv_out_en == !powered_down)
        else $error("receiver output enables wrong");
    a_wake_bound: assert property ($fell(powered_down)
        |-> ##[1:WAKE_MAX] (tx_out_en || powered_down)) else $error("wake took too long");
    a_ready_wake: assert property ($rose(ready) |-> tx_out_en && !$past(powered_down))
        else $error("ready rose outside power-up");
    // a transition acts one edge late, so quiet inputs are needed one cycle ahead
    a_expired_hold: assert property (
        $stable(tx_data_in) && $stable(rx_data_in) ##1 (powered_down && idle_expired
        && !auto_disable_input) |=> powered_down) else $error("left powerdown without cause");
    a_edge_wakes: assert property (
        shutdown_override_input && !($stable(tx_data_in) && $stable(rx_data_in))
        ##1 shutdown_override_input |=> !powered_down) else $error("transition did not wake");
    a_invalid_low: assert property (inv_cnt_ff >= INVALID_CYCLES + 64'h4 |-> !invalid_n)
        else $error("invalid flag stayed high");
    a_valid_high: assert property ((|rx_level_valid) [*8] |-> invalid_n)
        else $error("invalid flag stayed low");
    c_wake: cover property ($fell(powered_down));
    c_idle_off: cover property ($rose(powered_down) && shutdown_override_input);
    c_flag_low: cover property ($fell(invalid_n));
endmodule : tpd_checker

bind tpd_powerdown_ctrl tpd_checker #(.NUM_TX(NUM_TX), .NUM_RX(NUM_RX),
    .INVALID_CYCLES(INVALID_CYCLES)) u_chk (.clock, .resetn, .shutdown_override_input,
    .auto_disable_input, .tx_data_in, .rx_data_in, .rx_level_valid, .charge_pump_en,
    .tx_out_en, .rx_inv_out_en, .rx_monitor_out_en, .ready, .invalid_n, .powered_down,
    .idle_expired);

/* verif/testbench.sv */
// testbench: directed scenarios for the transceiver powerdown control
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, resetn, shutdown_override_input, auto_disable_input, pump_rail_ok;
    logic [2:0] tx_data_in;
    logic [4:0] rx_data_in, rx_level_valid;
    logic [1:0] mode, man_ctl;
    logic rail_slow, charge_pump_en, tx_out_en, rx_inv_out_en, rx_monitor_out_en;
    logic ready, invalid_n, powered_down, idle_expired;
    int err_total = 0;
    int n_checks = 0;
    int n;

    tpd_powerdown_ctrl #(.IDLE_CYCLES(64'hC8), .INVALID_CYCLES(64'h1E), .VALID_CYCLES(64'h4),
        .WAKE_CYCLES(64'h32)) u_dut (.clock, .resetn, .shutdown_override_input,
        .auto_disable_input, .tx_data_in, .rx_data_in, .rx_level_valid, .pump_rail_ok,
        .charge_pump_en, .tx_out_en, .rx_inv_out_en, .rx_monitor_out_en, .ready,
        .invalid_n, .powered_down, .idle_expired);
    tpd_host_model u_host (.clock, .mode, .man_ctl, .rail_slow, .charge_pump_en, .invalid_n,
        .shutdown_override_input, .auto_disable_input, .pump_rail_ok);

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : cyc

    task automatic chk(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t: got %b expected %b", $time, got, exp);
        end
    endtask : chk

    function automatic logic pick(input int sel);
        return sel == 0 ? powered_down : sel == 1 ? tx_out_en : invalid_n;
    endfunction : pick

    // running out of a wait counts as a mismatch and ends the run
    task automatic wt(input int sel, input logic v, input int lim, output int k);
        for (k = 0; pick(sel) !== v; k++) begin
            if (k == lim) begin
                err_total++;
                $display("ERROR %0t: wait ran out", $time);
                conclude();
            end
            cyc(1);
        end
    endtask : wt

    task automatic t_manual();
        chk(rx_monitor_out_en, 1'b1);
        man_ctl = 2'h3;
        wt(0, 1'b0, 5, n);
        chk(n == 1, 1'b1);
        cyc(250);
        chk(powered_down, 1'b0);
        chk(ready & tx_out_en & charge_pump_en & rx_inv_out_en, 1'b1);
        man_ctl = 2'h1;
        cyc(2);
        chk(powered_down, 1'b1);
        chk(charge_pump_en | tx_out_en, 1'b0);
        chk(rx_inv_out_en | ready, 1'b0);
        chk(rx_monitor_out_en, 1'b1);
        rail_slow = 1'b1;
        man_ctl = 2'h3;
        wt(1, 1'b1, 60, n);
        chk(n >= 48 && n <= 54, 1'b1);
        rail_slow = 1'b0;
        $display("manual control done");
    endtask : t_manual

    task automatic t_idle();
        man_ctl = 2'h2;
        cyc(150);
        chk(powered_down, 1'b0);
        wt(0, 1'b1, 80, n);
        chk(n >= 48 && n <= 56, 1'b1);
        chk(idle_expired, 1'b1);
        cyc(60);
        chk(powered_down, 1'b1);
        tx_data_in = 3'h1;
        wt(0, 1'b0, 5, n);
        chk(n == 2, 1'b1);
        wt(1, 1'b1, 25, n);
        $display("inactivity powerdown done");
    endtask : t_idle

    task automatic t_hold();
        man_ctl = 2'h0;
        cyc(3);
        chk(idle_expired, 1'b1);
        man_ctl = 2'h2;
        cyc(20);
        chk(powered_down, 1'b1);
        rx_data_in = 5'h10;
        wt(0, 1'b0, 5, n);
        chk(n == 2, 1'b1);
        $display("manual hold done");
    endtask : t_hold

    task automatic t_invalid();
        man_ctl = 2'h3;
        rx_level_valid = 5'h00;
        wt(2, 1'b0, 40, n);
        chk(n >= 32 && n <= 33, 1'b1);
        chk(powered_down, 1'b0);
        rx_level_valid = 5'h04;
        wt(2, 1'b1, 10, n);
        chk(n >= 5 && n <= 6, 1'b1);
        $display("invalid detector done");
    endtask : t_invalid

    task automatic t_tied();
        mode = 2'h1;
        rx_level_valid = 5'h00;
        wt(0, 1'b1, 40, n);
        rx_level_valid = 5'h1F;
        wt(0, 1'b0, 10, n);
        mode = 2'h3;
        rx_level_valid = 5'h00;
        wt(0, 1'b1, 40, n);
        rx_level_valid = 5'h1F;
        cyc(12);
        chk(powered_down, 1'b1);
        tx_data_in = 3'h3;
        wt(0, 1'b0, 5, n);
        $display("flag driven control done");
    endtask : t_tied

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    initial begin
        resetn = 1'b0;
        tx_data_in = 3'h0;
        rx_data_in = 5'h00;
        rx_level_valid = 5'h1F;
        mode = 2'h0;
        man_ctl = 2'h1;
        rail_slow = 1'b0;
        cyc(12);
        resetn = 1'b1;
        t_manual();
        t_idle();
        t_hold();
        t_invalid();
        t_tied();
        conclude();
    end
endmodule : testbench
